// File: pkg/pin_mux_pkg.sv
package pin_mux_pkg;

    // ************************************************
    // register offsets
    // ************************************************
    localparam logic [7:0] ADDR_INDICATOR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_GPIO_CONFIG = 8'h04;
    localparam logic [7:0] ADDR_GPIO_DATA_DIR = 8'h08;
    localparam logic [7:0] ADDR_STRAP_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_EEE_SOFT_STRAP = 8'h10;

    // ************************************************
    // field positions
    // ************************************************
    localparam int CFG_LED_EN_LSB = 0;
    localparam int CFG_FUNC_LSB = 8;
    localparam int FUNC_W = 3;
    localparam int GPIO_OD_LSB = 0;
    localparam int GPIO_DATA_LSB = 0;
    localparam int GPIO_DIR_LSB = 8;
    localparam int STAT_EEE_BIT = 0;
    localparam int STAT_SIZE_BIT = 1;
    localparam int EEE_EN_LSB = 0;

    // ************************************************
    // reset values
    // ************************************************
    localparam logic [1:0] LED_EN_RST = 2'h0;
    localparam logic [2:0] FUNC_RST = 3'h0;
    localparam logic [1:0] GPIO_OD_RST = 2'h0;
    localparam logic [1:0] GPIO_DATA_RST = 2'h0;
    localparam logic [1:0] GPIO_DIR_RST = 2'h0;

    // function codes that select open-drain/open-source drive
    localparam logic [7:0] FUNC_OPEN_DRAIN_SET = 8'hF0;

    // ************************************************
    // bus encodings
    // ************************************************
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'h0;

endpackage : pin_mux_pkg

// File: rtl/pin_cell.sv
`timescale 1ns/10ps
module pin_cell
    import pin_mux_pkg::*;
(
    input wire logic ref_clk, // system clock
    input wire logic sys_rst, // sync reset, high
    input wire logic ledEnable, // 1 led use, 0 gpio use
    input wire logic ledLit, // led should light
    input wire logic ledOpenDrain, // led open drive style
    input wire logic ledActiveLow, // latched strap level
    input wire logic gpioOpenDrain, // gpio open-drain style
    input wire logic gpioDir, // 1 output
    input wire logic gpioData, // gpio output value
    output logic padOut, // pad output value
    output logic padOe // pad output enable
);

    // ************************************************
    // pad driver selection
    // ************************************************
    // pad stays released in reset so the strap is readable
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            padOut <= 1'h0;
            padOe <= 1'h0;
        end else if (ledEnable) begin
            if (!ledOpenDrain) begin
                padOut <= ledLit;
                padOe <= 1'h1;
            end else begin
                padOut <= !ledActiveLow;
                padOe <= ledLit;
            end
        end else if (!gpioDir) begin
            padOut <= 1'h0;
            padOe <= 1'h0;
        end else if (gpioOpenDrain) begin
            padOut <= 1'h0;
            padOe <= !gpioData;
        end else begin
            padOut <= gpioData;
            padOe <= 1'h1;
        end
    end

    // ************************************************
    // checks
    // ************************************************
    // pad released in gpio input use
    gpio_input_quiet_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !ledEnable && !gpioDir |=> !padOe)
        else $error("pad driven while gpio input");

    open_drain_high_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !ledEnable && gpioDir && gpioOpenDrain |=> !(padOe && padOut))
        else $error("open-drain gpio drove high");

endmodule : pin_cell

// File: rtl/led_gpio_strap_pin_mux.sv
`timescale 1ns/10ps
// How it works
// - pin three follows led logic when its enable is set, else gpio.
// - pin two follows led logic when its enable is set, else gpio.
// - function field picks push-pull or open-drain/open-source led drive.
// - open led polarity comes from that pin's latched strap.
// - gpio is push-pull out, open-drain out or schmitt input.
// - latched low-power strap is default of both per-port enable bits.
// - eeprom size strap loads a hard setting software cannot change.
// - size strap low means small eeprom, 1K to 16K bits.
// - size strap high means large eeprom, 32K to 512K bits.
// - straps captured at every reset release and held afterwards.
module led_gpio_strap_pin_mux
    import pin_mux_pkg::*;
(
    input wire logic ref_clk, // 40 MHz system clock
    input wire logic sys_rst, // sync reset, high
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // 1 write
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    output logic [31:0] hrdata, // read data
    input wire logic [1:0] ledLit, // led activity, [0] pin two
    input wire logic [1:0] padIn, // pad level, [0] pin two
    output logic [1:0] padOut, // pad output value
    output logic [1:0] padOe, // pad output enable
    output logic [1:0] eeeEnable, // per-port eee enable
    output logic eepromLarge // 1 large eeprom class
);

    // ************************************************
    // bus address phase
    // ************************************************
    logic addrTake;
    logic wrPend_reg;
    logic rdPend_reg;
    logic [7:0] addr_reg;
    logic addrHigh_reg;
    logic wrSizeOk_reg;
    logic wrEn;
    logic [31:0] readWord;

    assign addrTake = hsel && htrans[1] && hready;
    assign wrEn = wrPend_reg && !addrHigh_reg && wrSizeOk_reg;

    // capture address phase; reads get one wait state
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wrPend_reg <= 1'h0;
            rdPend_reg <= 1'h0;
            addr_reg <= 8'h00;
            addrHigh_reg <= 1'h0;
            wrSizeOk_reg <= 1'h0;
        end else begin
            wrPend_reg <= addrTake && hwrite;
            rdPend_reg <= addrTake && !hwrite;
            if (addrTake) begin
                addr_reg <= haddr[7:0];
                addrHigh_reg <= |haddr[31:8];
                wrSizeOk_reg <= hsize == HSIZE_WORD;
            end
        end
    end

    // ready drops for the cycle after a read is taken
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            hreadyout <= 1'h1;
        end else begin
            hreadyout <= !(addrTake && !hwrite);
        end
    end

    // response is always okay
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            hresp <= HRESP_OKAY;
        end else begin
            hresp <= HRESP_OKAY;
        end
    end

    // ************************************************
    // strap capture
    // ************************************************
    logic capture_reg;
    logic eeeStrap_reg;
    logic sizeStrap_reg;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            capture_reg <= 1'h1;
        end else begin
            capture_reg <= 1'h0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            eeeStrap_reg <= 1'h0;
            sizeStrap_reg <= 1'h0;
        end else if (capture_reg) begin
            eeeStrap_reg <= padIn[1];
            sizeStrap_reg <= padIn[0];
        end
    end

    // hard strap, no bus write path
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            eepromLarge <= 1'h0;
        end else if (capture_reg) begin
            eepromLarge <= padIn[0];
        end
    end

    // soft strap, strap default then software
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            eeeEnable <= 2'h0;
        end else if (capture_reg) begin
            eeeEnable <= {2{padIn[1]}};
        end else if (wrEn && addr_reg == ADDR_EEE_SOFT_STRAP) begin
            eeeEnable <= hwdata[EEE_EN_LSB +: 2];
        end
    end

    // ************************************************
    // configuration registers
    // ************************************************
    logic [1:0] ledEnable_reg;
    logic [FUNC_W-1:0] funcSel_reg;
    logic [1:0] gpioOd_reg;
    logic [1:0] gpioData_reg;
    logic [1:0] gpioDir_reg;
    logic [1:0] padIn_reg;
    logic ledOpen;

    // indicator config: led enables and function field
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ledEnable_reg <= LED_EN_RST;
            funcSel_reg <= FUNC_RST;
        end else if (wrEn && addr_reg == ADDR_INDICATOR_CONFIG) begin
            ledEnable_reg <= hwdata[CFG_LED_EN_LSB +: 2];
            funcSel_reg <= hwdata[CFG_FUNC_LSB +: FUNC_W];
        end
    end

    // gpio drive style per pin
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            gpioOd_reg <= GPIO_OD_RST;
        end else if (wrEn && addr_reg == ADDR_GPIO_CONFIG) begin
            gpioOd_reg <= hwdata[GPIO_OD_LSB +: 2];
        end
    end

    // gpio data and direction per pin
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            gpioData_reg <= GPIO_DATA_RST;
            gpioDir_reg <= GPIO_DIR_RST;
        end else if (wrEn && addr_reg == ADDR_GPIO_DATA_DIR) begin
            gpioData_reg <= hwdata[GPIO_DATA_LSB +: 2];
            gpioDir_reg <= hwdata[GPIO_DIR_LSB +: 2];
        end
    end

    // pad levels seen by software
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            padIn_reg <= 2'h0;
        end else begin
            padIn_reg <= padIn;
        end
    end

    assign ledOpen = FUNC_OPEN_DRAIN_SET[funcSel_reg];

    // ************************************************
    // read path
    // ************************************************
    // word for the pending read address
    always_comb begin
        readWord = 32'h0000_0000;
        if (!addrHigh_reg) begin
            unique case (addr_reg)
                ADDR_INDICATOR_CONFIG: begin
                    readWord[CFG_LED_EN_LSB +: 2] = ledEnable_reg;
                    readWord[CFG_FUNC_LSB +: FUNC_W] = funcSel_reg;
                end
                ADDR_GPIO_CONFIG: begin
                    readWord[GPIO_OD_LSB +: 2] = gpioOd_reg;
                end
                ADDR_GPIO_DATA_DIR: begin
                    readWord[GPIO_DATA_LSB +: 2] = padIn_reg;
                    readWord[GPIO_DIR_LSB +: 2] = gpioDir_reg;
                end
                ADDR_STRAP_STATUS: begin
                    readWord[STAT_EEE_BIT] = eeeStrap_reg;
                    readWord[STAT_SIZE_BIT] = eepromLarge;
                end
                ADDR_EEE_SOFT_STRAP: begin
                    readWord[EEE_EN_LSB +: 2] = eeeEnable;
                end
                default: begin
                    readWord = 32'h0000_0000;
                end
            endcase
        end
    end

    // read data loaded in the wait cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            hrdata <= 32'h0000_0000;
        end else if (rdPend_reg) begin
            hrdata <= readWord;
        end
    end

    // ************************************************
    // pin cells, [0] pin two, [1] pin three
    // ************************************************
    // pin two led or gpio
    pin_cell pinTwoCell (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .ledEnable(ledEnable_reg[0]),
        .ledLit(ledLit[0]),
        .ledOpenDrain(ledOpen),
        .ledActiveLow(sizeStrap_reg),
        .gpioOpenDrain(gpioOd_reg[0]),
        .gpioDir(gpioDir_reg[0]),
        .gpioData(gpioData_reg[0]),
        .padOut(padOut[0]),
        .padOe(padOe[0])
    );

    pin_cell pinThreeCell (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .ledEnable(ledEnable_reg[1]),
        .ledLit(ledLit[1]),
        .ledOpenDrain(ledOpen),
        .ledActiveLow(eeeStrap_reg),
        .gpioOpenDrain(gpioOd_reg[1]),
        .gpioDir(gpioDir_reg[1]),
        .gpioData(gpioData_reg[1]),
        .padOut(padOut[1]),
        .padOe(padOe[1])
    );

    // ************************************************
    // checks
    // ************************************************
    gpio_three_input_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !ledEnable_reg[1] && !gpioDir_reg[1] |=> !padOe[1])
        else $error("pin three driven in gpio input use");

    led_two_pushpull_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ledEnable_reg[0] && !ledOpen && ledLit[0] |=> padOe[0] && padOut[0])
        else $error("pin two push-pull led not lit");

    led_open_idle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ledEnable_reg[1] && ledOpen && !ledLit[1] |=> !padOe[1])
        else $error("open led driven while dark");

    led_polarity_three_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ledEnable_reg[1] && ledOpen && ledLit[1] |=> padOe[1] && (padOut[1] == !eeeStrap_reg))
        else $error("pin three led polarity wrong");

    gpio_two_opendrain_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !ledEnable_reg[0] && gpioDir_reg[0] && gpioOd_reg[0] && !gpioData_reg[0]
        |=> padOe[0] && !padOut[0])
        else $error("pin two open-drain low not driven");

    eee_default_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !sys_rst && capture_reg |=> eeeEnable == {2{$past(padIn[1])}} && eeeStrap_reg == $past(padIn[1]))
        else $error("eee default not taken from strap");

    hard_strap_fixed_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !capture_reg |=> $stable(eepromLarge))
        else $error("eeprom size setting changed");

    size_small_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !capture_reg && !sizeStrap_reg |-> !eepromLarge)
        else $error("small strap gave large class");

    size_large_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !capture_reg && sizeStrap_reg |-> eepromLarge)
        else $error("large strap gave small class");

    strap_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !capture_reg |=> $stable(eeeStrap_reg) && $stable(sizeStrap_reg) && !capture_reg)
        else $error("strap changed after capture");

    led_ignores_gpio_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ledEnable_reg[1] && !ledOpen |=> padOe[1] && padOut[1] == $past(ledLit[1]))
        else $error("gpio setting reached led pin");

    read_wait_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        addrTake && !hwrite |=> !hreadyout ##1 hreadyout && hrdata == $past(readWord))
        else $error("read answer timing wrong");

endmodule : led_gpio_strap_pin_mux

// File: testbench/pad_partner.sv
`timescale 1ns/10ps
// ************************************************
// board side of the two shared pads
// ************************************************
module pad_partner (
    input wire logic [1:0] padOut, // device pad value
    input wire logic [1:0] padOe, // device drives pad
    input wire logic [1:0] strapLevel, // strap resistor level
    input wire logic [1:0] extOe, // external load drives pad
    input wire logic [1:0] extVal, // external drive value
    output logic [1:0] padIn // resolved pad level
);
    // device drive wins, then the external load, then the strap resistor
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            padIn[i] = padOe[i] ? padOut[i] : (extOe[i] ? extVal[i] : strapLevel[i]);
        end
    end
endmodule : pad_partner

// File: testbench/tb_led_gpio_strap_pin_mux.sv
`timescale 1ns/10ps
module tb_led_gpio_strap_pin_mux;
    import pin_mux_pkg::*;
    logic ref_clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp, eepromLarge, pinProbe, rdPhase, largeExp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, ledLit, padIn, padOut, padOe, eeeEnable, strapLevel, extOe, extVal, rnd, eeeExp;
    logic [2:0] hsize;
    logic [31:0] expQ[$];
    int nErrors, samplesChecked, cycleCount;

    // ************************************************
    // design and board model
    // ************************************************
    assign hready = hreadyout; // single slave
    led_gpio_strap_pin_mux led_gpio_strap_pin_mux_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ledLit(ledLit), .padIn(padIn),
        .padOut(padOut), .padOe(padOe), .eeeEnable(eeeEnable), .eepromLarge(eepromLarge));
    pad_partner pad_partner_i (.padOut(padOut), .padOe(padOe), .strapLevel(strapLevel), .extOe(extOe),
        .extVal(extVal), .padIn(padIn));

    // 25 ns clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // ************************************************
    // checking
    // ************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            nErrors++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finishTest();
        if (nErrors == 0 && samplesChecked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finishTest

    // takes the oldest note whenever read data or a pin probe appears; cuts a hang short
    always @(posedge ref_clk) begin
        if (rdPhase && hready) check(hrdata, expQ.pop_front());
        // response must stay okay on every read
        if (rdPhase && hready) check({31'h0, hresp}, {31'h0, HRESP_OKAY});
        if (pinProbe) check({25'h0, eeeEnable, eepromLarge, padOe, padOut}, expQ.pop_front());
        if (sys_rst) rdPhase <= 1'b0;
        else if (hready) rdPhase <= hsel && htrans[1] && !hwrite;
        cycleCount++;
        // run needs well under a thousand cycles
        if (cycleCount > 20000) begin
            nErrors++;
            finishTest();
        end
    end

    // ************************************************
    // bus and pin tasks
    // ************************************************
    task automatic addrPhase(input logic [7:0] a, input logic wr, input logic [2:0] sz);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        hsize <= sz;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
    endtask : addrPhase

    task automatic busWrite(input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz);
        addrPhase(a, 1'b1, sz);
        hwdata <= d;
        do @(posedge ref_clk); while (hready !== 1'b1);
    endtask : busWrite

    task automatic busRead(input logic [7:0] a, input logic [31:0] e);
        expQ.push_back(e);
        addrPhase(a, 1'b0, HSIZE_WORD);
        do @(posedge ref_clk); while (hready !== 1'b1);
    endtask : busRead

    // lets config land on the pins, then notes the pin and strap outputs
    task automatic probe(input logic [1:0] oe, input logic [1:0] out);
        repeat (3) @(posedge ref_clk);
        expQ.push_back({25'h0, eeeExp, largeExp, oe, out});
        pinProbe <= 1'b1;
        @(posedge ref_clk);
        pinProbe <= 1'b0;
    endtask : probe

    task automatic doReset(input logic [1:0] s);
        strapLevel <= s;
        sys_rst <= 1'b1;
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        eeeExp = {2{s[1]}};
        largeExp = s[0];
    endtask : doReset

    // ************************************************
    // scenarios
    // ************************************************
    initial begin
        {hsel, hwrite, htrans, hwdata, haddr, ledLit, extOe, extVal, pinProbe} = '0;
        hsize = HSIZE_WORD;
        sys_rst = 1'b1;
        strapLevel = 2'b10;
        nErrors = 0;
        samplesChecked = 0;
        cycleCount = 0;
        void'($urandom(32'hF847A921));
        doReset(2'b10);
        probe(2'b00, 2'b00);
        busRead(ADDR_STRAP_STATUS, 32'h1);
        busRead(ADDR_EEE_SOFT_STRAP, 32'h3);
        busRead(ADDR_INDICATOR_CONFIG, 32'h0);
        busWrite(ADDR_EEE_SOFT_STRAP, 32'h0, HSIZE_WORD);
        eeeExp = 2'b00;
        busWrite(ADDR_STRAP_STATUS, 32'hFFFFFFFF, HSIZE_WORD);
        busRead(ADDR_STRAP_STATUS, 32'h1);
        rnd = 2'($urandom);
        busWrite(ADDR_GPIO_DATA_DIR, {22'h0, 2'h3, 6'h0, rnd}, HSIZE_WORD);
        probe(2'b11, rnd);
        busWrite(ADDR_GPIO_CONFIG, 32'h3, HSIZE_WORD);
        probe(~rnd, 2'b00);
        busWrite(ADDR_GPIO_DATA_DIR, 32'h0, HSIZE_WORD);
        extOe <= 2'b11;
        extVal <= rnd ^ 2'b01;
        busRead(ADDR_GPIO_DATA_DIR, {30'h0, rnd ^ 2'b01});
        extOe <= 2'b00;
        // gpio drives high while led use is tested
        busWrite(ADDR_GPIO_CONFIG, 32'h0, HSIZE_WORD);
        busWrite(ADDR_GPIO_DATA_DIR, 32'h303, HSIZE_WORD);
        for (int f = 0; f < 8; f++) begin
            rnd = 2'($urandom);
            ledLit <= rnd;
            busWrite(ADDR_INDICATOR_CONFIG, {21'h0, 3'(f), 8'h03}, HSIZE_WORD);
            if (f < 4) probe(2'b11, rnd);
            else probe(rnd, 2'b01);
        end
        // pin two led, pin three gpio
        busWrite(ADDR_INDICATOR_CONFIG, 32'h701, HSIZE_WORD);
        probe({1'b1, rnd[0]}, 2'b11);
        // pin three led, pin two gpio
        busWrite(ADDR_INDICATOR_CONFIG, 32'h002, HSIZE_WORD);
        probe(2'b11, {rnd[1], 1'b1});
        // non-word write and unmapped place
        busWrite(ADDR_INDICATOR_CONFIG, 32'h3, 3'h0);
        busRead(ADDR_INDICATOR_CONFIG, 32'h2);
        busWrite(8'h40, 32'hFFFF, HSIZE_WORD);
        busRead(8'h40, 32'h0);
        doReset(2'b01);
        repeat (2) @(posedge ref_clk);
        strapLevel <= 2'b10;
        probe(2'b00, 2'b00);
        busRead(ADDR_STRAP_STATUS, 32'h2);
        rnd = 2'($urandom);
        ledLit <= rnd;
        busWrite(ADDR_INDICATOR_CONFIG, 32'h403, HSIZE_WORD);
        probe(rnd, 2'b10);
        finishTest();
    end
endmodule : tb_led_gpio_strap_pin_mux
